// ==== verilog/srs_defines.svh ====
// Purpose: Bit positions and reset values of the receive status register
// Assumes: 16-bit register, bit 0 the least significant
// Notes:   Definitions only
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

`define SRS_BIT_MODEM_CHANGE 15
`define SRS_BIT_RING         14
`define SRS_BIT_SEND_PERMIT  13
`define SRS_BIT_LINE_SIGNAL  12
`define SRS_BIT_REVERSE_RX   10
`define SRS_BIT_RX_COMPLETE  7
`define SRS_BIT_RX_IRQ_EN    6
`define SRS_BIT_MODEM_IRQ_EN 5
`define SRS_BIT_TAPE_ADVANCE 0

`define SRS_LINE_COUNT       4
`define SRS_BOTH_EDGE_MASK   4'he
`define SRS_RST_BIT          1'b0
`define SRS_RST_WORD         16'h0000

`endif

// ==== verilog/srs_pkg.sv ====
// Purpose: Shared types of the receive status logic
// Assumes: Nothing beyond the defines header
// Notes:   Line order matches the edge detector generate index
package srs_pkg;

  typedef logic [15:0] srs_word_t;

  typedef enum {
    SRS_LINE_RING,
    SRS_LINE_PERMIT,
    SRS_LINE_SIGNAL,
    SRS_LINE_REVERSE
  } srs_line_t;

endpackage : srs_pkg

// ==== verilog/srs_edge_detect.sv ====
// Purpose: Transition detector for one modem status line
// Assumes: Line is synchronous to clk
// Notes:   BOTH_EDGES=0 reports rising changes only
`timescale 1ns/1ns
`include "srs_defines.svh"
module srs_edge_detect #(
  parameter bit BOTH_EDGES = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic lineIn,
  output logic      lineLast,
  output logic      edgeSeen
);
  logic next_lineLast;

  always_comb
  begin
    next_lineLast = lineIn;
    if (BOTH_EDGES)
      edgeSeen = lineIn ^ lineLast;
    else
      edgeSeen = lineIn & ~lineLast;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      lineLast <= `SRS_RST_BIT;
    else
      lineLast <= next_lineLast;
  end

endmodule : srs_edge_detect

// ==== verilog/srs_status.sv ====
// Purpose: Receive status register with modem change and done flags
// Assumes: All strobes are one-cycle pulses synchronous to clk
// Notes:   Read data is captured on the read strobe and held
// Summary of operation
// - A qualifying modem line transition sets modem-change bit 15 unless bus initialize coincides.
// - Ring sets the modem-change bit only when it rises.
// - Carrier, send permit and reverse rx set it on both edges.
// - Modem-change flag with bit 5 enable raises the receiver request.
// - A status register read clears the modem-change flag unless a qualifying transition coincides.
// - Bus initialize clears the modem-change flag.
// - Ring, permit, signal, reverse rx read in bits 14, 13, 12, 10.
// - Bit 13 reads one while the send permit input is on.
// - Bit 12 reads one while a line signal is being received.
// - Bit 10 follows the reverse channel line, one for space.
// - A stored character sets the receive-complete bit 7.
// - Receive-complete setting clears the receiver-active flag.
// - Receive-complete with bit 6 enable raises the receiver request.
// - Bus initialize clears the receive-complete flag.
// - Receive buffer access clears the receive-complete flag.
// - Tape advance bit set holds receive-complete cleared.
// - Enables in bits 6 and 5 are written, readable, init cleared.
// - After service, no new request until condition or enable drops.
// - Tape advance bit 0 is write-only and reads as zero.
`timescale 1ns/1ns
`include "srs_defines.svh"
module srs_status (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              busInitialize,
  input  wire logic              statusReadStrobe,
  input  wire logic              statusWriteStrobe,
  input  wire srs_pkg::srs_word_t busDataIn,
  input  wire logic              bufferAccess,
  input  wire logic              charStored,
  input  wire logic              startBitSeen,
  input  wire logic              irqAck,
  input  wire logic              ringIn,
  input  wire logic              sendPermitIn,
  input  wire logic              lineSignalIn,
  input  wire logic              reverseRxIn,
  output srs_pkg::srs_word_t     statusData,
  output logic                   rxIrqRequest,
  output logic                   rxActive,
  output logic                   tapeAdvance
);
  import srs_pkg::*;

  logic [`SRS_LINE_COUNT-1:0] lineNow;
  logic [`SRS_LINE_COUNT-1:0] lineEdge;
  logic                       anyEdge;
  logic                       modemChange;
  logic                       rxComplete;
  logic                       rxIrqEnable;
  logic                       modemIrqEnable;
  logic                       irqArmed;
  logic                       irqCond;
  srs_word_t                  next_statusData;
  logic                       next_modemChange;
  logic                       next_rxComplete;
  logic                       next_rxIrqEnable;
  logic                       next_modemIrqEnable;
  logic                       next_irqArmed;
  logic                       next_rxIrqRequest;
  logic                       next_rxActive;
  logic                       next_tapeAdvance;

  // Register image as software sees it
  function automatic srs_word_t packStatus(
    input logic       change,
    input logic [3:0] lines,
    input logic       done,
    input logic       rxEn,
    input logic       mdEn
  );
    srs_word_t w;
    w = `SRS_RST_WORD;
    w[`SRS_BIT_MODEM_CHANGE] = change;
    w[`SRS_BIT_RING]         = lines[SRS_LINE_RING];
    w[`SRS_BIT_SEND_PERMIT]  = lines[SRS_LINE_PERMIT];
    w[`SRS_BIT_LINE_SIGNAL]  = lines[SRS_LINE_SIGNAL];
    w[`SRS_BIT_REVERSE_RX]   = lines[SRS_LINE_REVERSE];
    w[`SRS_BIT_RX_COMPLETE]  = done;
    w[`SRS_BIT_RX_IRQ_EN]    = rxEn;
    w[`SRS_BIT_MODEM_IRQ_EN] = mdEn;
    return w;
  endfunction : packStatus

  assign lineNow = {reverseRxIn, lineSignalIn, sendPermitIn, ringIn};

  // Ring counts rising changes only, the others every change
  genvar gi;
  generate
    for (gi = 0; gi < `SRS_LINE_COUNT; gi++)
    begin : g_line
      srs_edge_detect #(
        .BOTH_EDGES (1'((`SRS_BOTH_EDGE_MASK >> gi) & 4'h1))
      ) u_edge (
        .clk      (clk),
        .rst      (rst),
        .lineIn   (lineNow[gi]),
        .lineLast (),
        .edgeSeen (lineEdge[gi])
      );
    end
  endgenerate

  assign anyEdge = |lineEdge;
  assign irqCond = (rxComplete & rxIrqEnable)
                 | (modemChange & modemIrqEnable);

  // Flags: initialize first, tape advance hold next, then hardware set beats software clear
  always_comb
  begin
    next_modemChange = modemChange;
    if (busInitialize)
      next_modemChange = 1'b0;
    else if (anyEdge)
      next_modemChange = 1'b1;
    else if (statusReadStrobe)
      next_modemChange = 1'b0;

    next_rxComplete = rxComplete;
    if (busInitialize)
      next_rxComplete = 1'b0;
    else if (tapeAdvance)
      next_rxComplete = 1'b0;
    else if (charStored)
      next_rxComplete = 1'b1;
    else if (bufferAccess)
      next_rxComplete = 1'b0;

    next_rxActive = rxActive;
    if (busInitialize)
      next_rxActive = 1'b0;
    else if (startBitSeen)
      next_rxActive = 1'b1;
    else if (charStored)
      next_rxActive = 1'b0;
  end

  // Control bits loaded from the bus
  always_comb
  begin
    next_rxIrqEnable    = rxIrqEnable;
    next_modemIrqEnable = modemIrqEnable;
    next_tapeAdvance    = tapeAdvance;
    if (busInitialize)
    begin
      next_rxIrqEnable    = 1'b0;
      next_modemIrqEnable = 1'b0;
      next_tapeAdvance    = 1'b0;
    end
    else if (statusWriteStrobe)
    begin
      next_rxIrqEnable    = busDataIn[`SRS_BIT_RX_IRQ_EN];
      next_modemIrqEnable = busDataIn[`SRS_BIT_MODEM_IRQ_EN];
      next_tapeAdvance    = busDataIn[`SRS_BIT_TAPE_ADVANCE];
    end
    else if (startBitSeen)
      next_tapeAdvance = 1'b0;
  end

  // Request is one-shot per assertion of its condition
  always_comb
  begin
    next_irqArmed = irqArmed;
    if (busInitialize || !irqCond)
      next_irqArmed = 1'b1;
    else if (irqAck)
      next_irqArmed = 1'b0;
    next_rxIrqRequest = irqCond & irqArmed & ~irqAck
                      & ~busInitialize;
  end

  // Read data latched at the read strobe
  always_comb
  begin
    next_statusData = statusData;
    if (statusReadStrobe)
      next_statusData = packStatus(modemChange, lineNow, rxComplete,
                                   rxIrqEnable, modemIrqEnable);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      modemChange    <= `SRS_RST_BIT;
      rxComplete     <= `SRS_RST_BIT;
      rxActive       <= `SRS_RST_BIT;
      rxIrqEnable    <= `SRS_RST_BIT;
      modemIrqEnable <= `SRS_RST_BIT;
      tapeAdvance    <= `SRS_RST_BIT;
      irqArmed       <= 1'b1;
      rxIrqRequest   <= `SRS_RST_BIT;
      statusData     <= `SRS_RST_WORD;
    end
    else
    begin
      modemChange    <= next_modemChange;
      rxComplete     <= next_rxComplete;
      rxActive       <= next_rxActive;
      rxIrqEnable    <= next_rxIrqEnable;
      modemIrqEnable <= next_modemIrqEnable;
      tapeAdvance    <= next_tapeAdvance;
      irqArmed       <= next_irqArmed;
      rxIrqRequest   <= next_rxIrqRequest;
      statusData     <= next_statusData;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_change_sets_flag: assert property (
    anyEdge && !busInitialize |=> modemChange)
    else $error("modem change flag not set by line transition");

  a_ring_fall_quiet: assert property (
    !modemChange && !busInitialize && $fell(ringIn)
      && $stable(lineNow[3:1]) |=> !modemChange)
    else $error("ring falling edge set modem change flag");

  a_signal_fall_sets: assert property (
    $fell(lineSignalIn) && !busInitialize |=> modemChange)
    else $error("carrier drop did not set modem change flag");

  a_modem_irq: assert property (
    modemChange && modemIrqEnable && irqArmed && !irqAck
      && !busInitialize |=> rxIrqRequest)
    else $error("modem change request missing");

  a_read_clears: assert property (
    statusReadStrobe && !anyEdge |=> !modemChange)
    else $error("read did not clear modem change flag");

  a_init_clears: assert property (
    busInitialize |=> !modemChange && !rxComplete && !rxActive
      && !rxIrqEnable && !modemIrqEnable && !rxIrqRequest)
    else $error("initialize left state set");

  a_ring_mirror: assert property (
    statusReadStrobe |=> statusData[`SRS_BIT_RING] == $past(ringIn)
      && statusData[`SRS_BIT_MODEM_CHANGE] == $past(modemChange))
    else $error("ring or change bit read wrong");

  a_permit_mirror: assert property (
    statusReadStrobe |=>
      statusData[`SRS_BIT_SEND_PERMIT] == $past(sendPermitIn))
    else $error("send permit bit read wrong");

  a_signal_mirror: assert property (
    statusReadStrobe |=>
      statusData[`SRS_BIT_LINE_SIGNAL] == $past(lineSignalIn))
    else $error("line signal bit read wrong");

  a_reverse_mirror: assert property (
    statusReadStrobe |=>
      statusData[`SRS_BIT_REVERSE_RX] == $past(reverseRxIn))
    else $error("reverse channel bit read wrong");

  a_done_sets: assert property (
    charStored && !busInitialize && !tapeAdvance |=> rxComplete)
    else $error("receive complete not set");

  a_active_clears: assert property (
    charStored && !startBitSeen |=> !rxActive)
    else $error("receiver active not cleared by completion");

  a_rx_irq: assert property (
    rxComplete && rxIrqEnable && irqArmed && !irqAck
      && !busInitialize |=> rxIrqRequest)
    else $error("receive complete request missing");

  a_buffer_clears: assert property (
    bufferAccess && !charStored |=> !rxComplete)
    else $error("buffer access did not clear receive complete");

  a_tape_holds: assert property (
    tapeAdvance |=> !rxComplete)
    else $error("receive complete set while tape advance on");

  a_enable_write: assert property (
    statusWriteStrobe && !busInitialize |=>
      rxIrqEnable == $past(busDataIn[`SRS_BIT_RX_IRQ_EN])
      && modemIrqEnable == $past(busDataIn[`SRS_BIT_MODEM_IRQ_EN]))
    else $error("interrupt enables not loaded");

  a_no_rerequest: assert property (
    irqAck && irqCond && !busInitialize ##1 irqCond [*2]
      |=> !rxIrqRequest)
    else $error("request repeated without condition drop");

  a_tape_reads_zero: assert property (
    statusReadStrobe |=> statusData[`SRS_BIT_TAPE_ADVANCE] == 1'b0)
    else $error("tape advance bit visible on read");

  a_start_sets_active: assert property (
    startBitSeen && !busInitialize |=> rxActive)
    else $error("start bit did not set receiver active");

  c_modem_request: cover property (
    anyEdge ##1 modemChange && modemIrqEnable ##1 rxIrqRequest);
  c_rx_request: cover property (
    charStored ##1 rxComplete ##1 rxIrqRequest ##[1:4] irqAck);
  c_tape_hold: cover property (
    tapeAdvance && charStored ##1 !rxComplete);
  c_rearm: cover property (
    irqAck ##1 !irqCond ##1 irqCond ##1 rxIrqRequest);

endmodule : srs_status

// ==== test/srs_modem_model.sv ====
// Purpose: Modem model driving ring, carrier and handshake status lines
// Assumes: Lines are levels that change only at the falling clock edge
// Notes:   Line order follows srs_line_t: ring, permit, signal, reverse
`timescale 1ns/1ns
module srs_modem_model (
  input  wire logic       clk,
  input  wire logic [3:0] want,
  output logic            ring,
  output logic            permit,
  output logic            signal,
  output logic            reverse
);
  initial
  begin
    {reverse, signal, permit, ring} = 4'h0;
  end

  // Applies the requested line levels away from the sampling edge
  always @(negedge clk)
  begin
    {reverse, signal, permit, ring} <= want;
  end
endmodule : srs_modem_model

// ==== test/serial_receiver_status_logic_bench.sv ====
// Purpose: Self-checking bench for the receive status logic
// Assumes: Inputs change at the falling clock edge
// Notes:   Random modem line traffic from a fixed seed plus corner cases
`timescale 1ns/1ns
module serial_receiver_status_logic_bench;
  import srs_pkg::*;
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) \
  begin error_cnt++; $display("BAD %s exp %h got %h", nm, ex, got); end end

  logic       clk, rst, rdStrobe, wrStrobe;
  logic [4:0] ctl;
  srs_word_t  dataIn, statusWord, img;
  logic [3:0] want, prev;
  logic       ring, permit, signal, reverse;
  logic       irq, act, tape, e6, e5, chg;
  logic [31:0] v;
  int         error_cnt, check_count, seed, i;

  srs_modem_model u_modem (.clk(clk), .want(want), .ring(ring),
    .permit(permit), .signal(signal), .reverse(reverse));

  srs_status u_dut (.clk(clk), .rst(rst), .busInitialize(ctl[0]),
    .statusReadStrobe(rdStrobe), .statusWriteStrobe(wrStrobe),
    .busDataIn(dataIn), .bufferAccess(ctl[2]), .charStored(ctl[1]),
    .startBitSeen(ctl[3]), .irqAck(ctl[4]), .ringIn(ring),
    .sendPermitIn(permit), .lineSignalIn(signal), .reverseRxIn(reverse),
    .statusData(statusWord), .rxIrqRequest(irq), .rxActive(act),
    .tapeAdvance(tape));

  function automatic srs_word_t imageOf(input logic c, input logic [3:0] l,
                                        input logic d);
    imageOf = {c, l[0], l[1], l[2], 1'h0, l[3], 2'h0, d, e6, e5, 5'h00};
  endfunction : imageOf

  task give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task rd;
    @(negedge clk) rdStrobe = 1'h1;
    @(negedge clk) rdStrobe = 1'h0;
    img = statusWord;
  endtask : rd

  task wr(input srs_word_t d);
    @(negedge clk)
    begin
      wrStrobe = 1'h1;
      dataIn = d;
    end
    @(negedge clk) wrStrobe = 1'h0;
  endtask : wr

  task pulse(input int k);
    @(negedge clk) ctl[k] = 1'h1;
    @(negedge clk) ctl[k] = 1'h0;
  endtask : pulse

  task setLines(input logic [3:0] l);
    @(posedge clk) want = l;
    @(negedge clk);
  endtask : setLines

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    give_verdict;
  end

  initial
  begin
    rst = 1'h1; rdStrobe = 1'h0; wrStrobe = 1'h0; ctl = 5'h00;
    dataIn = 16'h0000; want = 4'h0; prev = 4'h0; e6 = 1'h0; e5 = 1'h0;
    seed = 91; error_cnt = 0; check_count = 0;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    rd;
    `CHK("idle", 16'h0000, img)
    wr(16'hffff);
    e6 = 1'h1;
    e5 = 1'h1;
    `CHK("tapeSet", 1'h1, tape)
    pulse(1);
    rd;
    `CHK("tapeHold", imageOf(1'h0, 4'h0, 1'h0), img)
    pulse(3);
    `CHK("actSet", 1'h1, act)
    pulse(1);
    `CHK("actClr", 1'h0, act)
    @(negedge clk);
    `CHK("rxReq", 1'h1, irq)
    pulse(4);
    `CHK("ackDrop", 1'h0, irq)
    repeat (3) @(negedge clk);
    `CHK("noReq", 1'h0, irq)
    rd;
    `CHK("done", imageOf(1'h0, 4'h0, 1'h1), img)
    pulse(2);
    rd;
    `CHK("bufClr", imageOf(1'h0, 4'h0, 1'h0), img)
    pulse(1);
    pulse(3);
    pulse(0);
    e6 = 1'h0;
    e5 = 1'h0;
    rd;
    `CHK("initClr", 16'h0000, img)
    `CHK("initAct", 1'h0, act)
    setLines(4'h4);
    pulse(0);
    rd;
    `CHK("initChg", imageOf(1'h0, 4'h4, 1'h0), img)
    prev = 4'h4;
    // First two steps: ring rises, then falls
    for (i = 0; i < 40; i++)
    begin
      v = $random(seed);
      if (i < 2)
        v[3:0] = (i == 0) ? 4'h5 : 4'h4;
      if (v[8])
      begin
        wr(v[31:16]);
        e6 = v[22];
        e5 = v[21];
      end
      chg = (~prev[0] & v[0]) | (|((prev ^ v[3:0]) & 4'he));
      setLines(v[3:0]);
      prev = v[3:0];
      rd;
      `CHK("image", imageOf(chg, prev, 1'h0), img)
      `CHK("modemReq", chg & e5, irq)
      rd;
      `CHK("readOnce", imageOf(1'h0, prev, 1'h0), img)
      `CHK("lineBits", {prev[1], prev[2], prev[3]},
           {img[13], img[12], img[10]})
    end
    give_verdict;
  end
endmodule : serial_receiver_status_logic_bench
